// File: common/flag_pkg.sv
`default_nettype none
package flag_pkg;

  // Register map (byte addresses on the register bus)
  localparam logic [7:0]  FLAGS_OFFSET = 8'hFC;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;

  // Bit positions inside the flag register
  localparam int          CARRY_BIT    = 7;
  localparam int          ZERO_BIT     = 6;
  localparam int          SIGN_BIT     = 5;
  localparam int          OVFL_BIT     = 4;
  localparam int          DECADJ_BIT   = 3;
  localparam int          HALFC_BIT    = 2;
  localparam int          FLAG_LSB     = 2;
  localparam int          NUM_FLAGS    = 6;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Per-flag update mode given by the ALU for each instruction
  typedef enum logic [2:0] {
    FLAG_KEEP   = 3'h0,
    FLAG_CLEAR  = 3'h1,
    FLAG_SET    = 3'h2,
    FLAG_RESULT = 3'h3,
    FLAG_UNDEF  = 3'h4
  } flag_mode_t;

  // Condition field codes
  localparam logic [3:0]  COND_NEVER          = 4'h0;
  localparam logic [3:0]  COND_SIGNED_LT      = 4'h1;
  localparam logic [3:0]  COND_SIGNED_LE      = 4'h2;
  localparam logic [3:0]  COND_UNSIGNED_LE    = 4'h3;
  localparam logic [3:0]  COND_OVERFLOW_SET   = 4'h4;
  localparam logic [3:0]  COND_NEGATIVE       = 4'h5;
  localparam logic [3:0]  COND_EQUAL          = 4'h6;
  localparam logic [3:0]  COND_UNSIGNED_LT    = 4'h7;
  localparam logic [3:0]  COND_ALWAYS         = 4'h8;
  localparam logic [3:0]  COND_SIGNED_GE      = 4'h9;
  localparam logic [3:0]  COND_SIGNED_GT      = 4'hA;
  localparam logic [3:0]  COND_UNSIGNED_GT    = 4'hB;
  localparam logic [3:0]  COND_OVERFLOW_CLEAR = 4'hC;
  localparam logic [3:0]  COND_POSITIVE       = 4'hD;
  localparam logic [3:0]  COND_NOT_EQUAL      = 4'hE;
  localparam logic [3:0]  COND_UNSIGNED_GE    = 4'hF;

endpackage
`default_nettype wire

// File: rtl/cond_eval.sv
`timescale 1ns/100ps
`default_nettype none
module cond_eval
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Request from the sequencer
  input  wire logic       cond_req,
  input  wire logic [3:0] condition_field,
  input  wire logic [7:0] flags,
  // Registered answer
  output var  logic       cond_valid_q,
  output var  logic       cond_true_q
);

  logic cond_valid_d;
  logic cond_true_d;

  function automatic logic eval(input logic [3:0] code, input logic [7:0] f);
    logic c;
    logic z;
    logic sv;
    c  = f[flag_pkg::CARRY_BIT];
    z  = f[flag_pkg::ZERO_BIT];
    sv = f[flag_pkg::SIGN_BIT] ^ f[flag_pkg::OVFL_BIT];
    case (code)
      flag_pkg::COND_ALWAYS:         eval = 1'b1;                 // RULE8
      flag_pkg::COND_NEVER:          eval = 1'b0;                 // RULE8
      flag_pkg::COND_UNSIGNED_LT:    eval = c;                    // RULE4
      flag_pkg::COND_UNSIGNED_GE:    eval = !c;                   // RULE4
      flag_pkg::COND_UNSIGNED_GT:    eval = !c && !z;             // RULE5
      flag_pkg::COND_UNSIGNED_LE:    eval = c || z;               // RULE6
      flag_pkg::COND_SIGNED_GE:      eval = !sv;                  // RULE7
      flag_pkg::COND_SIGNED_LT:      eval = sv;                   // RULE7
      flag_pkg::COND_SIGNED_GT:      eval = !(z || sv);           // RULE7
      flag_pkg::COND_SIGNED_LE:      eval = z || sv;              // RULE7
      flag_pkg::COND_EQUAL:          eval = z;                    // RULE8
      flag_pkg::COND_NOT_EQUAL:      eval = !z;                   // RULE8
      flag_pkg::COND_NEGATIVE:       eval = f[flag_pkg::SIGN_BIT];  // RULE8
      flag_pkg::COND_POSITIVE:       eval = !f[flag_pkg::SIGN_BIT]; // RULE8
      flag_pkg::COND_OVERFLOW_SET:   eval = f[flag_pkg::OVFL_BIT];  // RULE8
      default:                       eval = !f[flag_pkg::OVFL_BIT]; // RULE8
    endcase
  endfunction

  always_comb
  begin
    cond_valid_d = cond_req;
    cond_true_d  = cond_req ? eval(condition_field, flags) : 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cond_valid_q <= 1'b0;
      cond_true_q  <= 1'b0;
    end
    else
    begin
      cond_valid_q <= cond_valid_d;
      cond_true_q  <= cond_true_d;
    end
  end

  a_cond_carry: assert property (@(posedge clk) disable iff (!resetn) // RULE4
    cond_req && condition_field == flag_pkg::COND_UNSIGNED_LT
    |=> cond_true_q == $past(flags[flag_pkg::CARRY_BIT]))
    else $error("carry condition wrong");

  a_cond_no_carry: assert property (@(posedge clk) disable iff (!resetn) // RULE4
    cond_req && condition_field == flag_pkg::COND_UNSIGNED_GE
    |=> cond_true_q != $past(flags[flag_pkg::CARRY_BIT]))
    else $error("no-carry condition wrong");

  a_cond_ugt: assert property (@(posedge clk) disable iff (!resetn) // RULE5
    cond_req && condition_field == flag_pkg::COND_UNSIGNED_GT
    |=> cond_true_q == !($past(flags[flag_pkg::CARRY_BIT])
                         || $past(flags[flag_pkg::ZERO_BIT])))
    else $error("unsigned greater wrong");

  a_cond_ule: assert property (@(posedge clk) disable iff (!resetn) // RULE6
    cond_req && condition_field == flag_pkg::COND_UNSIGNED_LE
    |=> cond_true_q == ($past(flags[flag_pkg::CARRY_BIT])
                        || $past(flags[flag_pkg::ZERO_BIT])))
    else $error("unsigned less-or-equal wrong");

  a_cond_signed_ge: assert property (@(posedge clk) disable iff (!resetn) // RULE7
    cond_req && condition_field == flag_pkg::COND_SIGNED_GE
    |=> cond_true_q == ($past(flags[flag_pkg::SIGN_BIT])
                        == $past(flags[flag_pkg::OVFL_BIT])))
    else $error("signed greater-or-equal wrong");

  a_cond_signed_gt: assert property (@(posedge clk) disable iff (!resetn) // RULE7
    cond_req && condition_field == flag_pkg::COND_SIGNED_GT
    |=> cond_true_q == (!$past(flags[flag_pkg::ZERO_BIT])
                        && $past(flags[flag_pkg::SIGN_BIT])
                           == $past(flags[flag_pkg::OVFL_BIT])))
    else $error("signed greater wrong");

  a_cond_fixed: assert property (@(posedge clk) disable iff (!resetn) // RULE8
    cond_req && condition_field[2:0] == 3'h0
    |=> cond_valid_q && cond_true_q == $past(condition_field[3]))
    else $error("always/never condition wrong");

endmodule
`default_nettype wire

// File: rtl/flag_unit.sv
// Summary of operation
// (RULE1) Six status flags live in control register 252: C, Z, S, V, D, H.
// (RULE2) Software reads and writes the flag register at FC hex; writes replace.
// (RULE3) Each instruction clears, sets, computes, keeps or leaves undefined each flag.
// (RULE4) Code 0111 true when carry set; code 1111 true when carry clear.
// (RULE5) Code 1011 true only when carry and zero are both clear.
// (RULE6) Code 0011 true when carry or zero is set.
// (RULE7) Codes 1001/0001 test S xor V; 1010/0010 test Z or (S xor V).
// (RULE8) 1000 always, 0000 never; others test Z, S or V set and clear.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module flag_unit
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // AXI4-Lite write response
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // Flag update from the ALU, order {C,Z,S,V,D,H}
  input  wire logic        alu_update,
  input  wire logic [17:0] alu_flag_mode,
  input  wire logic [5:0]  alu_flag_value,
  // Condition request from the sequencer
  input  wire logic        cond_req,
  input  wire logic [3:0]  condition_field,
  // Results
  output var  logic [7:0]  status_flags,
  output var  logic        cond_valid,
  output var  logic        cond_true
);

  logic [7:0]  flags_q, flags_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        aw_full_q, aw_full_d;
  logic [7:0]  w_data_q, w_data_d;
  logic        w_en_q, w_en_d;
  logic        w_full_q, w_full_d;
  logic        awready_q, awready_d;
  logic        wready_q, wready_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        wr_commit;

  function automatic logic hits_flags(input logic [7:0] addr);
    hits_flags = (addr == flag_pkg::FLAGS_OFFSET); // RULE1
  endfunction

  assign wr_commit = aw_full_q && w_full_q && !bvalid_q;

  // Write channel: address and data are taken in either order
  always_comb
  begin
    aw_addr_d = aw_addr_q;
    aw_full_d = aw_full_q;
    w_data_d  = w_data_q;
    w_en_d    = w_en_q;
    w_full_d  = w_full_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (awvalid && awready_q)
    begin
      aw_addr_d = awaddr;
      aw_full_d = 1'b1;
      awready_d = 1'b0;
    end
    if (wvalid && wready_q)
    begin
      w_data_d = wdata[7:0];
      w_en_d   = wstrb[0];
      w_full_d = 1'b1;
      wready_d = 1'b0;
    end
    if (wr_commit)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = hits_flags(aw_addr_q) ? flag_pkg::RESP_OKAY
                                        : flag_pkg::RESP_SLVERR;
    end
    if (bvalid_q && bready)
    begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
  end

  // Flag register: a bus write wins over an ALU update in the same cycle
  always_comb
  begin
    flags_d = flags_q;
    if (alu_update)
    begin
      for (int i = 0; i < flag_pkg::NUM_FLAGS; i++)
      begin
        case (flag_pkg::flag_mode_t'(alu_flag_mode[3*i +: 3]))
          flag_pkg::FLAG_CLEAR:  flags_d[flag_pkg::FLAG_LSB + i] = 1'b0;
          flag_pkg::FLAG_SET:    flags_d[flag_pkg::FLAG_LSB + i] = 1'b1;
          flag_pkg::FLAG_RESULT:
            flags_d[flag_pkg::FLAG_LSB + i] = alu_flag_value[i]; // RULE3
          default:               flags_d[flag_pkg::FLAG_LSB + i] =
                                   flags_q[flag_pkg::FLAG_LSB + i];
        endcase
      end
    end
    if (wr_commit && w_en_q && hits_flags(aw_addr_q))
      flags_d = w_data_q; // RULE2
  end

  // Read channel
  always_comb
  begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (arvalid && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      if (hits_flags(araddr))
      begin
        rdata_d = {24'h000000, flags_q}; // RULE2
        rresp_d = flag_pkg::RESP_OKAY;
      end
      else
      begin
        rdata_d = 32'h00000000;
        rresp_d = flag_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid_q && rready)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags_q   <= flag_pkg::FLAGS_RESET;
      aw_addr_q <= 8'h00;
      aw_full_q <= 1'b0;
      w_data_q  <= 8'h00;
      w_en_q    <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= flag_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= flag_pkg::RESP_OKAY;
    end
    else
    begin
      flags_q   <= flags_d;
      aw_addr_q <= aw_addr_d;
      aw_full_q <= aw_full_d;
      w_data_q  <= w_data_d;
      w_en_q    <= w_en_d;
      w_full_q  <= w_full_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign status_flags = flags_q;

  cond_eval u_cond_eval
  (
    .clk             (clk),
    .resetn          (resetn),
    .cond_req        (cond_req),
    .condition_field (condition_field),
    .flags           (flags_q),
    .cond_valid_q    (cond_valid),
    .cond_true_q     (cond_true)
  );

  a_flags_write: assert property (@(posedge clk) disable iff (!resetn) // RULE2
    wr_commit && w_en_q && aw_addr_q == flag_pkg::FLAGS_OFFSET
    |=> flags_q == $past(w_data_q))
    else $error("flag write not stored");

  a_flags_read: assert property (@(posedge clk) disable iff (!resetn) // RULE1
    arvalid && arready && araddr == flag_pkg::FLAGS_OFFSET
    |=> rvalid && rresp == flag_pkg::RESP_OKAY
        && rdata == {24'h000000, $past(flags_q)})
    else $error("flag read wrong");

  a_flag_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE3
    alu_update && alu_flag_mode[17:15] == flag_pkg::FLAG_CLEAR && !wr_commit
    |=> !flags_q[flag_pkg::CARRY_BIT])
    else $error("carry clear failed");

  a_flag_keep: assert property (@(posedge clk) disable iff (!resetn) // RULE3
    alu_update && alu_flag_mode[2:0] == flag_pkg::FLAG_KEEP && !wr_commit
    |=> $stable(flags_q[flag_pkg::HALFC_BIT]))
    else $error("half-carry changed while kept");

endmodule
`default_nettype wire

// File: bench/tb_branch_condition_evaluator.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_branch_condition_evaluator;
  logic        clk;
  logic        resetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        alu_update;
  logic [17:0] alu_flag_mode;
  logic [5:0]  alu_flag_value;
  logic        cond_req;
  logic [3:0]  condition_field;
  logic [7:0]  status_flags;
  logic        cond_valid;
  logic        cond_true;
  int          num_errors;
  int          tests_run;
  int          seed;
  logic [7:0]  exp_f;
  logic        upd_p;
  logic [1:0]  q_b[$];
  logic [33:0] q_r[$];
  logic        q_c[$];
  logic [7:0]  q_f[$];
  logic [33:0] exp_w;

  flag_unit u_dut (.clk(clk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .alu_update(alu_update),
    .alu_flag_mode(alu_flag_mode), .alu_flag_value(alu_flag_value),
    .cond_req(cond_req), .condition_field(condition_field),
    .status_flags(status_flags), .cond_valid(cond_valid),
    .cond_true(cond_true));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Reference condition table, from flags {C,Z,S,V} at [7:4]
  function automatic logic cond_ref(input logic [3:0] c, input logic [7:0] f);
    logic cy, z, s, v;
    cy = f[7];
    z  = f[6];
    s  = f[5];
    v  = f[4];
    case (c)
      4'h0: return 1'b0;
      4'h8: return 1'b1;
      4'h7: return cy;
      4'hF: return !cy;
      4'hB: return !cy && !z;
      4'h3: return cy || z;
      4'h9: return !(s ^ v);
      4'h1: return s ^ v;
      4'hA: return !(z || (s ^ v));
      4'h2: return z || (s ^ v);
      4'h6: return z;
      4'hE: return !z;
      4'h5: return s;
      4'hD: return !s;
      4'h4: return v;
      default: return !v;
    endcase
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    q_b.push_back(er);
    awaddr  <= a;
    wdata   <= {$unsigned($random(seed)) & 32'hFFFFFF00} | {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    q_r.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Result watcher: pops the oldest note whenever a result shows
  always @(posedge clk)
  begin
    if (bvalid && bready)
    begin
      exp_w = 34'(q_b.pop_front());
      `CHK("bresp", exp_w[1:0], bresp)
    end
    if (rvalid && rready)
    begin
      exp_w = q_r.pop_front();
      `CHK("read", exp_w, {rresp, rdata})
    end
    if (cond_valid)
    begin
      exp_w = 34'(q_c.pop_front());
      `CHK("cond", exp_w[0], cond_true)
    end
    if (upd_p)
    begin
      exp_w = 34'(q_f.pop_front());
      `CHK("status_flags", exp_w[7:0], status_flags)
    end
    upd_p <= alu_update;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end

  initial
  begin
    logic [17:0] m;
    logic [5:0]  v;
    logic [7:0]  nf;
    logic [2:0]  md;
    int          pend;
    num_errors = 0;
    tests_run = 0;
    seed = 32'h5EA7AD81;
    resetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, alu_update, alu_flag_mode} = '0;
    {alu_flag_value, cond_req, condition_field} = '0;
    exp_f = flag_pkg::FLAGS_RESET;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    axi_rd(flag_pkg::FLAGS_OFFSET, {flag_pkg::RESP_OKAY, 24'h0, exp_f});
    repeat (4)
    begin
      exp_f = 8'($random(seed));
      axi_wr(flag_pkg::FLAGS_OFFSET, exp_f, 4'hF, flag_pkg::RESP_OKAY);
      axi_rd(flag_pkg::FLAGS_OFFSET, {flag_pkg::RESP_OKAY, 24'h0, exp_f});
    end
    // Masked byte and unmapped place must leave the flags alone
    axi_wr(flag_pkg::FLAGS_OFFSET, ~exp_f, 4'hE, flag_pkg::RESP_OKAY);
    axi_wr(8'hF8, ~exp_f, 4'hF, flag_pkg::RESP_SLVERR);
    axi_rd(8'hF8, {flag_pkg::RESP_SLVERR, 32'h0});
    axi_rd(flag_pkg::FLAGS_OFFSET, {flag_pkg::RESP_OKAY, 24'h0, exp_f});
    // A bus write committed with an ALU clear in the same cycle wins
    exp_f = 8'($random(seed)) | 8'hFC;
    fork
      axi_wr(flag_pkg::FLAGS_OFFSET, exp_f, 4'hF, flag_pkg::RESP_OKAY);
      begin
        @(posedge clk);
        q_f.push_back(exp_f);
        alu_update    <= 1'b1;
        alu_flag_mode <= 18'h09249;
        @(posedge clk);
        alu_update    <= 1'b0;
      end
    join
    // Back-to-back ALU updates with a condition query every cycle
    for (int i = 0; i < 96; i++)
    begin
      q_c.push_back(cond_ref(4'(i), exp_f));
      v = 6'($random(seed));
      nf = exp_f;
      for (int k = 0; k < 6; k++)
      begin
        md = 3'($unsigned($random(seed)) % 5);
        m[3*k +: 3] = md;
        if (md == 3'h1)
          nf[k+2] = 1'b0;
        else if (md == 3'h2)
          nf[k+2] = 1'b1;
        else if (md == 3'h3)
          nf[k+2] = v[k];
      end
      exp_f = nf;
      q_f.push_back(nf);
      alu_update      <= 1'b1;
      alu_flag_mode   <= m;
      alu_flag_value  <= v;
      cond_req        <= 1'b1;
      condition_field <= 4'(i);
      @(posedge clk);
    end
    alu_update <= 1'b0;
    cond_req   <= 1'b0;
    repeat (3) @(posedge clk);
    axi_rd(flag_pkg::FLAGS_OFFSET, {flag_pkg::RESP_OKAY, 24'h0, exp_f});
    repeat (3) @(posedge clk);
    pend = q_b.size() + q_r.size() + q_c.size() + q_f.size();
    `CHK("pending", 0, pend)
    conclude();
  end
endmodule
`default_nettype wire
